/* File: hw/dac_reg_control.sv */
`timescale 1ns/1ns
module dac_reg_control
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  output logic [11:0] out_code_ch0,
  output logic [11:0] out_code_ch1,
  output logic range_select_ch0,
  output logic range_select_ch1,
  output logic power_on_ch0,
  output logic power_on_ch1,
  output logic clear_n_ch0,
  output logic clear_n_ch1
);

  // ***************************************************************
  // code assembly
  // ***************************************************************
  function automatic logic [11:0] assemble(input logic mode_8bit, input logic [7:0] low,
                                           input logic [7:0] high);
    logic [11:0] code;
    code = {high[dac_ctrl_pkg::HIGH_NIBBLE_W-1:0], low};
    if (mode_8bit)
    begin
      code = {4'h0, low};
    end
    return code;
  endfunction

  // ***************************************************************
  // register decode
  // ***************************************************************
  logic [7:0] control_reg;
  logic [7:0] control_next;
  logic [7:0] low_reg [2];
  logic [7:0] high_reg [2];
  logic [11:0] held_reg [2];
  logic [11:0] out_code_reg [2];
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [7:0] addr_low [2];
  logic [7:0] addr_high [2];
  logic [1:0] wr_low;
  logic [1:0] wr_high;
  logic [1:0] clear_n_next;
  logic wr_control;
  logic sync_rise;

  assign addr_low[0] = dac_ctrl_pkg::ADDR_CH0_LOW;
  assign addr_low[1] = dac_ctrl_pkg::ADDR_CH1_LOW;
  assign addr_high[0] = dac_ctrl_pkg::ADDR_CH0_HIGH;
  assign addr_high[1] = dac_ctrl_pkg::ADDR_CH1_HIGH;

  assign wr_control = ce & sfr_wr & (sfr_addr == dac_ctrl_pkg::ADDR_CONTROL);
  assign control_next = wr_control ? sfr_wdata : control_reg;
  assign sync_rise = wr_control & sfr_wdata[dac_ctrl_pkg::BIT_SYNC]
                     & ~control_reg[dac_ctrl_pkg::BIT_SYNC];
  assign clear_n_next[0] = control_next[dac_ctrl_pkg::BIT_CLEAR0];
  assign clear_n_next[1] = control_next[dac_ctrl_pkg::BIT_CLEAR1];

  assign rdata_next = (sfr_addr == dac_ctrl_pkg::ADDR_CONTROL) ? control_reg :
                      (sfr_addr == dac_ctrl_pkg::ADDR_CH0_LOW) ? low_reg[0] :
                      (sfr_addr == dac_ctrl_pkg::ADDR_CH0_HIGH) ? high_reg[0] :
                      (sfr_addr == dac_ctrl_pkg::ADDR_CH1_LOW) ? low_reg[1] :
                      (sfr_addr == dac_ctrl_pkg::ADDR_CH1_HIGH) ? high_reg[1] : 8'h00;

  // ***************************************************************
  // control register and read data
  // ***************************************************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      control_reg <= dac_ctrl_pkg::CONTROL_RESET;
      rdata_reg <= 8'h00;
    end
    else if (ce)
    begin
      control_reg <= control_next;
      if (sfr_rd)
      begin
        rdata_reg <= rdata_next;
      end
    end
  end

  // ***************************************************************
  // per-channel data, held code and output
  // ***************************************************************
  for (genvar i = 0; i < 2; i++)
  begin : g_chan
    logic [7:0] low_next;
    logic [11:0] held_next;
    logic load;

    assign wr_low[i] = ce & sfr_wr & (sfr_addr == addr_low[i]);
    assign wr_high[i] = ce & sfr_wr & (sfr_addr == addr_high[i]);
    assign low_next = wr_low[i] ? sfr_wdata : low_reg[i];
    // the low-byte write is the trigger, so the high byte must already be in place
    assign load = sync_rise | (control_reg[dac_ctrl_pkg::BIT_SYNC] & wr_low[i]);
    assign held_next = load ?
                       assemble(control_next[dac_ctrl_pkg::BIT_MODE], low_next, high_reg[i]) :
                       held_reg[i];

    always_ff @(posedge clk)
    begin
      if (!rst_n)
      begin
        low_reg[i] <= dac_ctrl_pkg::DATA_RESET;
        high_reg[i] <= dac_ctrl_pkg::DATA_RESET;
        held_reg[i] <= 12'h000;
        out_code_reg[i] <= 12'h000;
      end
      else if (ce)
      begin
        low_reg[i] <= low_next;
        if (wr_high[i])
        begin
          high_reg[i] <= sfr_wdata;
        end
        held_reg[i] <= held_next;
        out_code_reg[i] <= clear_n_next[i] ? held_next : 12'h000;
      end
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  assign sfr_rdata = rdata_reg;
  assign out_code_ch0 = out_code_reg[0];
  assign out_code_ch1 = out_code_reg[1];
  assign range_select_ch1 = control_reg[dac_ctrl_pkg::BIT_RANGE1];
  assign range_select_ch0 = control_reg[dac_ctrl_pkg::BIT_RANGE0];
  assign power_on_ch1 = control_reg[dac_ctrl_pkg::BIT_POWER1];
  assign power_on_ch0 = control_reg[dac_ctrl_pkg::BIT_POWER0];
  assign clear_n_ch1 = control_reg[dac_ctrl_pkg::BIT_CLEAR1];
  assign clear_n_ch0 = control_reg[dac_ctrl_pkg::BIT_CLEAR0];

  // ***************************************************************
  // checks
  // ***************************************************************
  chk_mode_eight_bit: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_low[0] && !wr_control && control_reg[7] && control_reg[2] && control_reg[3])
    |=> out_code_ch0 == {4'h0, $past(sfr_wdata)})
    else $error("8-bit mode code wrong on channel 0");

  chk_code_right_justified: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_low[1] && !wr_control && !control_reg[7] && control_reg[2] && control_reg[4])
    |=> out_code_ch1 == {$past(high_reg[1][3:0]), $past(sfr_wdata)})
    else $error("12-bit code assembly wrong on channel 1");

  chk_range_ch1: assert property (@(posedge clk) disable iff (!rst_n)
    wr_control |=> range_select_ch1 == $past(sfr_wdata[6]))
    else $error("channel 1 range not taken from bit 6");

  chk_range_ch0: assert property (@(posedge clk) disable iff (!rst_n)
    wr_control |=> range_select_ch0 == $past(sfr_wdata[5]))
    else $error("channel 0 range not taken from bit 5");

  chk_clear_forces_zero: assert property (@(posedge clk) disable iff (!rst_n)
    !clear_n_ch1 |-> out_code_ch1 == 12'h000)
    else $error("cleared channel 1 not at zero");

  chk_clear_zero_ch0: assert property (@(posedge clk) disable iff (!rst_n)
    !clear_n_ch0 |-> out_code_ch0 == 12'h000)
    else $error("cleared channel 0 not at zero");

  chk_eight_bit_sync: assert property (@(posedge clk) disable iff (!rst_n)
    (sync_rise && sfr_wdata[7] && sfr_wdata[3])
    |=> out_code_ch0 == {4'h0, $past(low_reg[0])})
    else $error("8-bit sync update used high byte on channel 0");

  chk_read_low_byte: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && sfr_rd && sfr_addr == 8'hF9) |=> sfr_rdata == $past(low_reg[0]))
    else $error("F9 read did not return channel 0 low byte");

  chk_sync_holds: assert property (@(posedge clk) disable iff (!rst_n)
    (!control_reg[2] && !wr_control && clear_n_ch0) |=> $stable(out_code_ch0))
    else $error("output moved while sync low");

  chk_sync_rise_update: assert property (@(posedge clk) disable iff (!rst_n)
    (sync_rise && sfr_wdata[4] && !sfr_wdata[7])
    |=> out_code_ch1 == {$past(high_reg[1][3:0]), $past(low_reg[1])})
    else $error("sync set did not update channel 1");

  chk_immediate_update: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_low[0] && control_reg[2] && control_reg[3] && !wr_control)
    |=> out_code_ch0[7:0] == $past(sfr_wdata))
    else $error("low write did not update channel 0 at once");

  chk_power_bits: assert property (@(posedge clk) disable iff (!rst_n)
    wr_control |=> power_on_ch0 == $past(sfr_wdata[0]) && power_on_ch1 == $past(sfr_wdata[1]))
    else $error("power bits not taken from control write");

  chk_reset_values: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(rst_n) |-> control_reg == 8'h04 && low_reg[0] == 8'h00 && high_reg[1] == 8'h00
                     && out_code_ch0 == 12'h000)
    else $error("reset values wrong");

  chk_data_map: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && sfr_wr && sfr_addr == 8'hFC) |=> high_reg[1] == $past(sfr_wdata))
    else $error("FC write did not reach channel 1 high byte");

endmodule

/* File: hw/dac_ctrl_pkg.sv */
package dac_ctrl_pkg;

  // ***************************************************************
  // register addresses
  // ***************************************************************
  localparam logic [7:0] ADDR_CH0_LOW = 8'hF9;
  localparam logic [7:0] ADDR_CH0_HIGH = 8'hFA;
  localparam logic [7:0] ADDR_CH1_LOW = 8'hFB;
  localparam logic [7:0] ADDR_CH1_HIGH = 8'hFC;
  localparam logic [7:0] ADDR_CONTROL = 8'hFE;

  // ***************************************************************
  // reset values
  // ***************************************************************
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] CONTROL_RESET = 8'h04;

  // ***************************************************************
  // converter_control field positions
  // ***************************************************************
  // bit order from 7 down to 0
  localparam int BIT_MODE = 7;
  localparam int BIT_RANGE1 = 6;
  localparam int BIT_RANGE0 = 5;
  localparam int BIT_CLEAR1 = 4;
  localparam int BIT_CLEAR0 = 3;
  localparam int BIT_SYNC = 2;
  localparam int BIT_POWER1 = 1;
  localparam int BIT_POWER0 = 0;

  // ***************************************************************
  // code widths
  // ***************************************************************
  localparam int CODE_W = 12;
  localparam int HIGH_NIBBLE_W = 4;

endpackage

/* File: verification/tb_dual_dac_register_control.sv */
`timescale 1ns/1ns
module tb_dual_dac_register_control;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic obs = 1'b0;
  logic rd_q = 1'b0;
  logic [7:0] sfr_rdata;
  logic [11:0] out_code_ch0;
  logic [11:0] out_code_ch1;
  logic range_select_ch0;
  logic range_select_ch1;
  logic power_on_ch0;
  logic power_on_ch1;
  logic clear_n_ch0;
  logic clear_n_ch1;
  logic [31:0] seen;
  logic [31:0] exp_q [$];
  logic [7:0] m_ctl = 8'h04;
  logic [7:0] m_data [4] = '{default: 8'h00};
  logic [11:0] m_held [2] = '{default: 12'h000};
  logic [7:0] lf = 8'h39;
  int error_cnt = 0;
  int check_count = 0;

  dac_reg_control DUT (.clk(clk), .rst_n(rst_n), .ce(ce), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .out_code_ch0(out_code_ch0), .out_code_ch1(out_code_ch1),
    .range_select_ch0(range_select_ch0), .range_select_ch1(range_select_ch1),
    .power_on_ch0(power_on_ch0), .power_on_ch1(power_on_ch1),
    .clear_n_ch0(clear_n_ch0), .clear_n_ch1(clear_n_ch1));

  assign seen = {2'h0, range_select_ch1, range_select_ch0, clear_n_ch1, clear_n_ch0,
    power_on_ch1, power_on_ch0, out_code_ch1, out_code_ch0};

  always #10 clk = ~clk;

  // ***************************************************************
  // reference model and drivers
  // ***************************************************************
  function automatic logic [7:0] lfsr_step(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  function automatic logic [11:0] code_of(input int ch);
    if (m_ctl[dac_ctrl_pkg::BIT_MODE]) return {4'h0, m_data[2 * ch]};
    return {m_data[2 * ch + 1][3:0], m_data[2 * ch]};
  endfunction

  task automatic acc(input logic w, r, c, o, input logic [7:0] a, d);
    @(negedge clk);
    sfr_wr = w;
    sfr_rd = r;
    ce = c;
    obs = o;
    sfr_addr = a;
    sfr_wdata = d;
  endtask

  task automatic wr(input logic [7:0] a, d);
    logic was_sync;
    was_sync = m_ctl[dac_ctrl_pkg::BIT_SYNC];
    if (a == dac_ctrl_pkg::ADDR_CONTROL) m_ctl = d;
    if (a >= 8'hF9 && a <= 8'hFC) m_data[a - 8'hF9] = d;
    if (a == dac_ctrl_pkg::ADDR_CONTROL && !was_sync && d[dac_ctrl_pkg::BIT_SYNC])
    begin
      m_held[0] = code_of(0);
      m_held[1] = code_of(1);
    end
    if (m_ctl[dac_ctrl_pkg::BIT_SYNC] && (a == 8'hF9 || a == 8'hFB))
      m_held[a[1]] = code_of(int'(a[1]));
    acc(1'b1, 1'b0, 1'b1, 1'b0, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    logic [7:0] v;
    v = (a >= 8'hF9 && a <= 8'hFC) ? m_data[a - 8'hF9] : 8'h00;
    if (a == dac_ctrl_pkg::ADDR_CONTROL) v = m_ctl;
    exp_q.push_back({24'h000000, v});
    acc(1'b0, 1'b1, 1'b1, 1'b0, a, 8'h00);
  endtask

  task automatic look();
    exp_q.push_back({2'h0, m_ctl[6:3], m_ctl[1:0],
      m_ctl[4] ? m_held[1] : 12'h000, m_ctl[3] ? m_held[0] : 12'h000});
    acc(1'b0, 1'b0, 1'b1, 1'b1, 8'h00, 8'h00);
  endtask

  // ***************************************************************
  // output monitor
  // ***************************************************************
  task automatic compare(input logic [31:0] got);
    logic [31:0] want;
    want = exp_q.pop_front();
    check_count++;
    if (got !== want)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, want);
    end
  endtask

  always @(posedge clk)
  begin
    rd_q <= rst_n && ce && sfr_rd;
    if (rd_q) compare({24'h000000, sfr_rdata});
    if (obs) compare(seen);
  end

  task automatic tally_and_finish();
    if (error_cnt == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    #400000;
    error_cnt++;
    tally_and_finish();
  end

  // ***************************************************************
  // stimulus
  // ***************************************************************
  initial
  begin
    repeat (20) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    look();
    for (int i = 0; i < 6; i++) rd(8'hF9 + 8'(i));
    wr(8'hFD, 8'h5A);
    rd(8'hFD);
    acc(1'b1, 1'b0, 1'b0, 1'b0, dac_ctrl_pkg::ADDR_CONTROL, 8'hFF);
    rd(dac_ctrl_pkg::ADDR_CONTROL);
    for (int i = 0; i < 48; i++)
    begin
      lf = lfsr_step(lf);
      wr(dac_ctrl_pkg::ADDR_CONTROL, lf);
      for (int k = 0; k < 4; k++)
      begin
        lf = lfsr_step(lf);
        wr(8'hFA - 8'(k[0]) + 8'(k[1] * 2), lf);
      end
      look();
      wr(dac_ctrl_pkg::ADDR_CONTROL, m_ctl | 8'h04);
      look();
      rd(8'hF9 + 8'(lf[1:0]));
    end
    acc(1'b0, 1'b0, 1'b1, 1'b0, 8'h00, 8'h00);
    repeat (3) @(posedge clk);
    tally_and_finish();
  end
endmodule
